// ==== rtl/iwd_pkg.sv ====
package iwd_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_TB_COUNT = 8'hF1;
  localparam logic [7:0] OFS_TB_CTRL = 8'hF2;
  localparam logic [7:0] OFS_WD_CMP = 8'hF4;
  localparam logic [7:0] OFS_WD_KEY = 8'hF6;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hF8;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF9;
  // ****************************************************************
  // reset values and fields
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h17;
  localparam logic [7:0] CMP_RST = 8'h7F;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] KEY_DISABLE = 8'hA5;
  localparam logic [7:0] TB_MAX = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [6:0] ZERO7 = 7'h00;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int CTRL_CLR_BIT = 3;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CMP_CLR_BIT = 7;
  localparam int CMP_W = 7;
  // ****************************************************************
  // interrupt status bits
  // ****************************************************************
  localparam int IRQ_W = 2;
  localparam int ST_TB_OVF = 0;
  localparam int ST_WD_MATCH = 1;
  // ****************************************************************
  // prescaler: ratio is 2 to the power of (sel + PRE_BASE)
  // ****************************************************************
  localparam int PRE_W = 10;
  localparam int PRE_BASE = 3;
endpackage

// ==== rtl/iwd_prescaler.sv ====
`timescale 1ns/1ps
// free running divider, one-cycle tick every 2^(sel+3) clocks
module iwd_prescaler #(
  parameter int PRE_W = iwd_pkg::PRE_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [iwd_pkg::SEL_W-1:0] sel_in,
  output logic tick_out
);
  logic [PRE_W-1:0] cnt_ff;
  logic [PRE_W-1:0] nxt_cnt;
  logic [PRE_W-1:0] mask;
  logic hit;

  // low (sel+3) bits set
  function automatic logic [PRE_W-1:0] div_mask(input logic [iwd_pkg::SEL_W-1:0] s);
    logic [PRE_W:0] one;
    one = {{PRE_W{1'b0}}, 1'b1};
    div_mask = PRE_W'((one << (s + iwd_pkg::PRE_BASE)) - one);
  endfunction

  // ****************************************************************
  // divider
  // ****************************************************************
  assign mask = div_mask(sel_in);
  assign hit = (cnt_ff & mask) == mask;
  assign nxt_cnt = cnt_ff + PRE_W'(1);

  // count always, tick registered
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_out <= hit;
    end
  end
endmodule // iwd_prescaler

// ==== rtl/iwd_top.sv ====
`timescale 1ns/1ps
// How it works
// - timebase counter runs freely, never halted
// - counter steps once per prescaled tick
// - wrap from max to zero raises interrupt
// - clear bit zeroes counter, self-clears next cycle
// - select field picks divide 8 to 1024
// - control register resets to 17h
// - mode bit picks watchdog or interval timer
// - watchdog counter matches low seven compare bits
// - match resets CPU or raises interrupt
// - key A5h suppresses watchdog reset
// - key resets to zero, reset armed
// - compare bit 7 clears watchdog counter
// - compare holds match value, resets 7Fh
// - timebase counter is read-only
module iwd_top (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [iwd_pkg::ADDR_W-1:0] addr_in,
  input wire logic [iwd_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [iwd_pkg::DATA_W-1:0] rd_data_out,
  output logic irq_out,
  output logic wdt_reset_out
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] tb_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] cmp_ff;
  logic [7:0] key_ff;
  logic [iwd_pkg::IRQ_W-1:0] stat_ff;
  logic [iwd_pkg::IRQ_W-1:0] mask_ff;
  logic [7:0] nxt_tb;
  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_cmp;
  logic [iwd_pkg::IRQ_W-1:0] nxt_stat;
  logic [iwd_pkg::IRQ_W-1:0] ev;
  logic [7:0] nxt_rd;
  logic tick;
  logic tb_ovf;
  logic wd_match;
  logic [6:0] wd_count;
  logic tb_clr;
  logic wd_clr;
  logic wd_mode;
  logic key_off;
  logic nxt_wdrst;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire wr_ctrl = wr_en_in && (addr_in == iwd_pkg::OFS_TB_CTRL);
  wire wr_cmp = wr_en_in && (addr_in == iwd_pkg::OFS_WD_CMP);
  wire wr_key = wr_en_in && (addr_in == iwd_pkg::OFS_WD_KEY);
  wire wr_mask = wr_en_in && (addr_in == iwd_pkg::OFS_IRQ_MASK);
  wire rd_stat = rd_en_in && (addr_in == iwd_pkg::OFS_IRQ_STAT);

  // ****************************************************************
  // field views
  // ****************************************************************
  assign tb_clr = ctrl_ff[iwd_pkg::CTRL_CLR_BIT];
  assign wd_clr = cmp_ff[iwd_pkg::CMP_CLR_BIT];
  assign wd_mode = ctrl_ff[iwd_pkg::CTRL_MODE_BIT];
  assign key_off = key_ff == iwd_pkg::KEY_DISABLE;

  // ****************************************************************
  // prescaler
  // ****************************************************************
  iwd_prescaler #(
    .PRE_W(iwd_pkg::PRE_W)
  ) u_pre (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sel_in(ctrl_ff[iwd_pkg::SEL_LSB +: iwd_pkg::SEL_W]),
    .tick_out(tick)
  );

  // ****************************************************************
  // timebase counter
  // ****************************************************************
  // wrap and step, clear takes precedence over the tick
  assign tb_ovf = tick && !tb_clr && (tb_ff == iwd_pkg::TB_MAX);
  assign nxt_tb = tb_clr ? iwd_pkg::ZERO8 : tb_ff + 8'h01;

  // no software write path reaches the counter
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tb_ff <= iwd_pkg::ZERO8;
    end else if (tick || tb_clr) begin
      tb_ff <= nxt_tb;
    end
  end

  // ****************************************************************
  // watchdog counter
  // ****************************************************************
  iwd_wd_counter #(
    .CMP_W(iwd_pkg::CMP_W)
  ) u_wd (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .step_in(tb_ovf),
    .clr_in(wd_clr),
    .cmp_in(cmp_ff[iwd_pkg::CMP_W-1:0]),
    .count_out(wd_count),
    .match_out(wd_match)
  );

  // ****************************************************************
  // control and compare registers
  // ****************************************************************
  // clear bits drop one cycle after they were written
  assign nxt_ctrl = wr_ctrl ? {3'h0, wr_data_in[4:0]}
                            : {ctrl_ff[7:4], 1'b0, ctrl_ff[2:0]};
  assign nxt_cmp = wr_cmp ? wr_data_in
                          : {1'b0, cmp_ff[6:0]};

  // register storage
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_ff <= iwd_pkg::CTRL_RST;
      cmp_ff <= iwd_pkg::CMP_RST;
      key_ff <= iwd_pkg::KEY_RST;
      mask_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cmp_ff <= nxt_cmp;
      if (wr_key) begin
        key_ff <= wr_data_in;
      end
      if (wr_mask) begin
        mask_ff <= wr_data_in[iwd_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // match outcome
  // ****************************************************************
  // reset in watchdog mode unless keyed off, interrupt in interval mode only
  assign nxt_wdrst = wd_match && wd_mode && !key_off;
  assign ev[iwd_pkg::ST_TB_OVF] = tb_ovf;
  assign ev[iwd_pkg::ST_WD_MATCH] = wd_match && !wd_mode;
  // read clears, a new event in the same cycle wins
  assign nxt_stat = (rd_stat ? '0 : stat_ff) | ev;

  // status, interrupt line and reset request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stat_ff <= '0;
      irq_out <= 1'b0;
      wdt_reset_out <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_out <= |(nxt_stat & mask_ff);
      wdt_reset_out <= nxt_wdrst;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // read mux, unmapped reads zero
  always_comb begin
    nxt_rd = iwd_pkg::ZERO8;
    case (addr_in)
      iwd_pkg::OFS_TB_COUNT: nxt_rd = tb_ff;
      iwd_pkg::OFS_TB_CTRL: nxt_rd = ctrl_ff;
      iwd_pkg::OFS_WD_CMP: nxt_rd = cmp_ff;
      iwd_pkg::OFS_WD_KEY: nxt_rd = key_ff;
      iwd_pkg::OFS_IRQ_STAT: nxt_rd = {6'h00, stat_ff};
      iwd_pkg::OFS_IRQ_MASK: nxt_rd = {6'h00, mask_ff};
      default: nxt_rd = iwd_pkg::ZERO8;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_data_out <= iwd_pkg::ZERO8;
    end else begin
      rd_data_out <= rd_en_in ? nxt_rd : iwd_pkg::ZERO8;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  ctrl_reset_a: assert property (
    $past(rst_in) |-> (ctrl_ff == iwd_pkg::CTRL_RST))
    else $error("control not 17h after reset");

  cmp_reset_a: assert property (
    $past(rst_in) |-> (cmp_ff == iwd_pkg::CMP_RST && key_ff == iwd_pkg::KEY_RST))
    else $error("compare or key wrong after reset");

  tb_step_a: assert property (
    (tick && !tb_clr) |=> (tb_ff == $past(tb_ff) + 8'h01))
    else $error("timebase did not step on tick");

  tb_hold_a: assert property (
    (!tick && !tb_clr) |=> $stable(tb_ff))
    else $error("timebase changed without tick");

  tb_wrap_a: assert property (
    tb_ovf |=> (tb_ff == iwd_pkg::ZERO8) && stat_ff[iwd_pkg::ST_TB_OVF])
    else $error("wrap did not flag overflow");

  tb_clear_a: assert property (
    (wr_ctrl && wr_data_in[iwd_pkg::CTRL_CLR_BIT]) |=> tb_clr ##1
      (!tb_clr && tb_ff == iwd_pkg::ZERO8))
    else $error("timebase clear sequence wrong");

  wd_clear_a: assert property (
    (wr_cmp && wr_data_in[iwd_pkg::CMP_CLR_BIT]) |=> wd_clr ##1
      (!wd_clr && wd_count == iwd_pkg::ZERO7))
    else $error("watchdog clear sequence wrong");

  wd_step_a: assert property (
    (tb_ovf && !wd_clr && wd_count != cmp_ff[6:0]) |=>
      (wd_count == $past(wd_count) + 7'h01))
    else $error("watchdog did not step on overflow");

  wd_match_a: assert property (
    (tb_ovf && !wd_clr && wd_count == cmp_ff[6:0]) |=>
      (wd_match && wd_count == iwd_pkg::ZERO7))
    else $error("watchdog match missed");

  wd_reset_a: assert property (
    (wd_match && wd_mode && !key_off) |=> wdt_reset_out)
    else $error("watchdog reset not raised");

  key_block_a: assert property (
    wdt_reset_out |-> ($past(key_ff) != iwd_pkg::KEY_DISABLE))
    else $error("reset raised while keyed off");

  wd_irq_a: assert property (
    (wd_match && !wd_mode) |=> (stat_ff[iwd_pkg::ST_WD_MATCH] && !wdt_reset_out))
    else $error("interval mode match not flagged");

  rd_count_a: assert property (
    (rd_en_in && addr_in == iwd_pkg::OFS_TB_COUNT) |=>
      (rd_data_out == $past(tb_ff)))
    else $error("counter read data wrong");

  irq_line_a: assert property (
    irq_out == $past(|(nxt_stat & mask_ff)))
    else $error("interrupt line mismatch");

  // ****************************************************************
  // register and flag assertions
  // ****************************************************************
  // bus side: read data stand one cycle only, writes land as written except control bits 7:5 and mask bits 7:2, which read zero
  rd_idle_a: assert property (
    !rd_en_in |=>
      (rd_data_out == iwd_pkg::ZERO8))
    else $error("read data not zero when idle");

  rd_ctrl_a: assert property (
    (rd_en_in && addr_in == iwd_pkg::OFS_TB_CTRL) |=>
      (rd_data_out == $past(ctrl_ff)))
    else $error("control read data wrong");

  ctrl_top_a: assert property (
    wr_ctrl |=>
      (ctrl_ff[7:5] == 3'h0 && ctrl_ff[2:0] == $past(wr_data_in[2:0])))
    else $error("control write wrong");

  cmp_write_a: assert property (
    wr_cmp |=>
      (cmp_ff == $past(wr_data_in)))
    else $error("compare write wrong");

  key_write_a: assert property (
    wr_key |=>
      (key_ff == $past(wr_data_in)))
    else $error("key write wrong");

  mask_write_a: assert property (
    wr_mask |=>
      (mask_ff == $past(wr_data_in[iwd_pkg::IRQ_W-1:0])))
    else $error("mask write wrong");

  // a write to the counter address must not move the counter
  tb_ro_a: assert property (
    (wr_en_in && addr_in == iwd_pkg::OFS_TB_COUNT && !tick && !tb_clr) |=>
      $stable(tb_ff))
    else $error("counter moved on write");

  // prescaler ticks are single pulses, never back to back
  tick_gap_a: assert property (
    tick |=>
      !tick)
    else $error("prescaler ticks back to back");

  // watchdog counter only moves on a wrap or a clear
  wd_hold_a: assert property (
    (!tb_ovf && !wd_clr) |=>
      $stable(wd_count))
    else $error("watchdog counter moved alone");

  // status bits stay until read, read leaves only new events
  stat_sticky_a: assert property (
    !rd_stat |=>
      ((stat_ff & $past(stat_ff)) == $past(stat_ff)))
    else $error("status bit lost without read");

  stat_clear_a: assert property (
    rd_stat |=>
      (stat_ff == $past(ev)))
    else $error("status read did not clear");

  irq_low_a: assert property (
    (mask_ff == '0) |=>
      !irq_out)
    else $error("interrupt raised while masked");

  // reset request is a one-cycle pulse, never when keyed off
  wd_pulse_a: assert property (
    wdt_reset_out |=>
      !wdt_reset_out)
    else $error("reset request longer than one cycle");

  wd_keyed_a: assert property (
    (wd_match && key_off) |=>
      !wdt_reset_out)
    else $error("reset raised with key set");

  tb_ovf_c: cover property (tb_ovf);
  wd_clear_c: cover property (wd_clr && tb_ovf);
  wd_reset_c: cover property (wdt_reset_out);
  wd_irq_c: cover property (wd_match && !wd_mode);
  key_off_c: cover property (wd_match && wd_mode && key_off);
endmodule // iwd_top

// ==== rtl/iwd_wd_counter.sv ====
`timescale 1ns/1ps
// 7-bit watchdog counter, clocked by timebase overflow
module iwd_wd_counter #(
  parameter int CMP_W = iwd_pkg::CMP_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic step_in,
  input wire logic clr_in,
  input wire logic [CMP_W-1:0] cmp_in,
  output logic [CMP_W-1:0] count_out,
  output logic match_out
);
  logic hit;
  logic [CMP_W-1:0] nxt_count;

  // ****************************************************************
  // compare and step
  // ****************************************************************
  assign hit = step_in && !clr_in && (count_out == cmp_in);
  assign nxt_count = (clr_in || hit) ? '0 : count_out + CMP_W'(1);

  // match restarts the count, clear holds it at zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count_out <= '0;
      match_out <= 1'b0;
    end else begin
      if (step_in || clr_in) begin
        count_out <= nxt_count;
      end
      match_out <= hit;
    end
  end
endmodule // iwd_wd_counter

// ==== tb/iwd_top_bench.sv ====
`timescale 1ns/1ps
module iwd_top_bench;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d;} iwd_row_t;
  logic sys_clk, rst, wr_en, rd_en, irq, wdt_rst;
  logic [7:0] addr, wdata, rdata, v0, v1;
  int err_total, n_checks, n, p;
  int pulses = 0;
  iwd_row_t rows [19];

  // block under test, every input driven by the bench
  iwd_top DUT (.sys_clk_in(sys_clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata), .irq_out(irq),
    .wdt_reset_out(wdt_rst));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count cycles with the cpu reset request high
  always @(posedge sys_clk) begin
    if (wdt_rst === 1'b1) pulses <= pulses + 1;
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // bounded wait for the interrupt line, n holds the cycles spent
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task automatic near(input int lo, input int hi);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // cut a hang short, tests take about 40000 cycles
  initial begin
    cyc(80000);
    err_total++;
    end_sim;
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    err_total = 0;
    n_checks = 0;
    rows = '{'{1'b0, 8'hF2, 8'h17}, '{1'b0, 8'hF4, 8'h7F}, '{1'b0, 8'hF6, 8'h00},
      '{1'b0, 8'hF9, 8'h00}, '{1'b0, 8'hF8, 8'h00}, '{1'b0, 8'hF3, 8'h00},
      '{1'b1, 8'hF2, 8'hE4}, '{1'b0, 8'hF2, 8'h04}, '{1'b1, 8'hF4, 8'hC5},
      '{1'b0, 8'hF4, 8'h45}, '{1'b1, 8'hF6, 8'hA5}, '{1'b0, 8'hF6, 8'hA5},
      '{1'b1, 8'hF9, 8'h03}, '{1'b0, 8'hF9, 8'h03}, '{1'b1, 8'hF8, 8'h03},
      '{1'b0, 8'hF8, 8'h00}, '{1'b1, 8'hF3, 8'hAA}, '{1'b0, 8'hF3, 8'h00},
      '{1'b1, 8'hF6, 8'h00}};
    cyc(2);
    rst <= 1'b0;
    chk({7'h00, irq}, 8'h00);
    // register table: reset values, access kinds, self-clearing compare bit 7
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rdc(rows[i].a, rows[i].d);
    end
    note("registers");
    wr(8'hF2, 8'h0F);
    wr(8'hF1, 8'hFF);
    rd(8'hF1, v0);
    chk({7'h00, v0 <= 8'h01}, 8'h01);
    rdc(8'hF2, 8'h07);
    note("timebase clear");
    // two read strobes exactly two prescaler periods apart
    for (int s = 0; s < 8; s++) begin
      wr(8'hF2, 8'(s));
      cyc(2 << (s + 3));
      rd(8'hF1, v0);
      cyc((2 << (s + 3)) - 2);
      rd(8'hF1, v1);
      chk(v1 - v0, 8'h02);
    end
    note("divider");
    wr(8'hF9, 8'h01);
    rd(8'hF8, v0);
    wr(8'hF2, 8'h08);
    wait_irq(3000);
    near(2030, 2080);
    wr(8'hF9, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    rd(8'hF8, v0);
    chk(v0 & 8'h01, 8'h01);
    wr(8'hF9, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    note("wrap interrupt");
    rd(8'hF8, v0);
    wr(8'hF9, 8'h02);
    wr(8'hF2, 8'h08);
    wr(8'hF4, 8'h82);
    wait_irq(8000);
    near(6100, 6200);
    rdc(8'hF8, 8'h03);
    wait_irq(8000);
    near(6100, 6200);
    chk(8'(pulses), 8'h00);
    note("interval mode");
    wr(8'hF9, 8'h00);
    wr(8'hF2, 8'h18);
    wr(8'hF4, 8'h80);
    rd(8'hF8, v0);
    p = pulses;
    cyc(2000);
    chk(8'(pulses - p), 8'h00);
    cyc(100);
    chk(8'(pulses - p), 8'h01);
    rdc(8'hF8, 8'h01);
    wr(8'hF6, 8'hA5);
    wr(8'hF2, 8'h18);
    wr(8'hF4, 8'h80);
    rd(8'hF8, v0);
    p = pulses;
    cyc(4200);
    chk(8'(pulses - p), 8'h00);
    rdc(8'hF8, 8'h01);
    wr(8'hF6, 8'h5A);
    wr(8'hF2, 8'h18);
    wr(8'hF4, 8'h80);
    p = pulses;
    cyc(2100);
    chk(8'(pulses - p), 8'h01);
    note("reset mode");
    wr(8'hF6, 8'h00);
    wr(8'hF2, 8'h18);
    wr(8'hF4, 8'h81);
    p = pulses;
    // software keeps the watchdog from matching
    repeat (6) begin
      cyc(1000);
      wr(8'hF4, 8'h81);
    end
    chk(8'(pulses - p), 8'h00);
    cyc(3000);
    chk(8'(pulses - p), 8'h01);
    note("watchdog service");
    @(posedge sys_clk);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rdc(8'hF2, 8'h17);
    rdc(8'hF4, 8'h7F);
    rdc(8'hF6, 8'h00);
    rdc(8'hF9, 8'h00);
    note("second reset");
    end_sim;
  end
endmodule // iwd_top_bench
